// [bbs_defs.vh]
// timing and width constants for the battery-backed sram host controller
`ifndef BBS_DEFS_VH
`define BBS_DEFS_VH
`define BBS_CLK_PERIOD_NS   100
`define BBS_ADDR_W          13
`define BBS_DATA_W          8
// device timing figures in ns
`define BBS_T_ACCESS_NS     70
`define BBS_T_CHIP_ACC_NS   70
`define BBS_T_OE_ACC_NS     35
`define BBS_T_HIZ_NS        25
`define BBS_T_WR_PULSE_NS   60
`define BBS_T_WR_CYCLE_NS   70
`define BBS_T_DATA_HOLD_NS  5
`define BBS_T_REC_NS        200000000
// cycle counts, least times rounded up, at least one cycle
`define BBS_CYC_UP(t) (((t) + `BBS_CLK_PERIOD_NS - 1) / `BBS_CLK_PERIOD_NS)
`define BBS_CYC(t) ((`BBS_CYC_UP(t) < 1) ? 1 : `BBS_CYC_UP(t))
`endif

// [bbs_delay_cnt.v]
// loadable down counter that signals when a wait has run out
`default_nettype none
module bbs_delay_cnt #(
  parameter W = 8
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         reset,
  // control
  input  wire         load,
  input  wire [W-1:0] value,
  // status
  output wire         done
);
  reg [W-1:0] cnt_r;

  // count down to zero, reload on demand
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // done ignores load, so a user may reload on done without a loop
  assign done = (cnt_r == {W{1'b0}});
endmodule
`default_nettype wire

// [bbs_host.v]
// host controller driving an 8k x 8 battery-backed sram over its pins
`include "bbs_defs.vh"
`default_nettype none
module bbs_host #(
  parameter REC_CYCLES = `BBS_CYC(`BBS_T_REC_NS)
) (
  // clock and reset
  input  wire                     ref_clk,
  input  wire                     reset,
  // user request side
  input  wire                     req_valid,
  input  wire                     req_write,
  input  wire [`BBS_ADDR_W-1:0]   req_addr,
  input  wire [`BBS_DATA_W-1:0]   req_wdata,
  output wire                     req_ready,
  output reg  [`BBS_DATA_W-1:0]   rsp_rdata,
  output reg                      rsp_valid,
  // supply status
  input  wire                     power_good,
  input  wire                     battery_mode,
  output wire                     mem_ready,
  // sram pins
  output reg  [`BBS_ADDR_W-1:0]   address_inputs,
  output reg                      chip_on_n,
  output reg                      output_drive_enable_n,
  output reg                      store_strobe_n,
  input  wire [`BBS_DATA_W-1:0]   data_lines_in,
  output reg  [`BBS_DATA_W-1:0]   data_lines_out,
  output reg                      data_lines_oe_n
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_RD   = 3'b001;
  localparam [2:0] ST_WR   = 3'b010;
  localparam [2:0] ST_WHLD = 3'b011;
  localparam [2:0] ST_GAP  = 3'b100;

  // read waits the address access time alone, which equals chip access and exceeds oe access
  localparam integer RD_CYC = `BBS_CYC(`BBS_T_ACCESS_NS);
  localparam integer WR_CYC = `BBS_CYC(`BBS_T_WR_PULSE_NS);
  localparam integer CY_CYC = `BBS_CYC(`BBS_T_WR_CYCLE_NS);
  localparam integer HZ_CYC = `BBS_CYC(`BBS_T_HIZ_NS);
  localparam [7:0] RD_WAIT = RD_CYC[7:0];
  localparam [7:0] WR_WAIT = ((WR_CYC > CY_CYC) ? WR_CYC[7:0] : CY_CYC[7:0]);
  localparam [7:0] GAP_WAIT = HZ_CYC[7:0];
  localparam [31:0] REC_LOAD = REC_CYCLES;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [7:0]  wait_val;
  reg         wait_load;
  wire        wait_done;
  reg         pg_d_r;
  reg         rec_load;
  wire        rec_done;
  wire        take;

  // one counter times strobe widths and read access
  bbs_delay_cnt #(.W(8)) u_wait (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (wait_load),
    .value   (wait_val),
    .done    (wait_done)
  );

  // recovery counter after power good returns
  bbs_delay_cnt #(.W(32)) u_rec (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (rec_load),
    .value   (REC_LOAD),
    .done    (rec_done)
  );

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pg_d_r <= 1'b0;
    end else begin
      pg_d_r <= power_good;
    end
  end

  always @* begin
    rec_load = power_good && !pg_d_r;
  end

  // battery mode implies power is bad; both hold the bus off
  assign mem_ready = power_good && pg_d_r && rec_done && !battery_mode;
  // accept only from idle with strobes high
  assign req_ready = (state_r == ST_IDLE) && mem_ready;
  // request taken at this edge
  assign take = req_valid && req_ready;

  // main access sequencer
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r               <= ST_IDLE;
      address_inputs        <= {`BBS_ADDR_W{1'b0}};
      chip_on_n             <= 1'b1;
      output_drive_enable_n <= 1'b1;
      store_strobe_n        <= 1'b1;
      data_lines_out        <= {`BBS_DATA_W{1'b0}};
      data_lines_oe_n       <= 1'b1;
      rsp_rdata             <= {`BBS_DATA_W{1'b0}};
      rsp_valid             <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            address_inputs <= req_addr;
            chip_on_n      <= 1'b0;
            if (req_write) begin
              store_strobe_n        <= 1'b0;
              output_drive_enable_n <= 1'b1;
              // data on bus from strobe fall
              data_lines_out        <= req_wdata;
              data_lines_oe_n       <= 1'b0;
            end else begin
              // read: store strobe high, oe low
              output_drive_enable_n <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (wait_done) begin
            rsp_rdata             <= data_lines_in;
            rsp_valid             <= 1'b1;
            chip_on_n             <= 1'b1;
            output_drive_enable_n <= 1'b1;
          end
        end
        ST_WR: begin
          if (wait_done) begin
            store_strobe_n <= 1'b1;
            chip_on_n      <= 1'b1;
          end
        end
        ST_WHLD: begin
          // one cycle of data and address hold
          data_lines_oe_n <= 1'b1;
        end
        ST_GAP: begin
          // let device outputs float before next drive
          data_lines_oe_n <= 1'b1;
        end
        default: begin
          // unknown state: release every strobe at once
          chip_on_n             <= 1'b1;
          output_drive_enable_n <= 1'b1;
          store_strobe_n        <= 1'b1;
          data_lines_oe_n       <= 1'b1;
        end
      endcase
    end
  end

  // load the shared wait counter on state entry
  always @* begin
    wait_load = 1'b0;
    wait_val  = 8'h00;
    if (take) begin
      wait_load = 1'b1;
      wait_val  = req_write ? (WR_WAIT - 8'h01) : (RD_WAIT - 8'h01);
    end else if ((state_r == ST_RD || state_r == ST_WR) && wait_done) begin
      wait_load = 1'b1;
      wait_val  = GAP_WAIT;
    end
  end

  // next state of the access sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = req_write ? ST_WR : ST_RD;
        end
      end
      ST_RD: begin
        if (wait_done) begin
          state_nxt = ST_GAP;
        end
      end
      ST_WR: begin
        if (wait_done) begin
          state_nxt = ST_WHLD;
        end
      end
      ST_WHLD: begin
        state_nxt = ST_GAP;
      end
      ST_GAP: begin
        // idle again only after the float gap
        if (wait_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end
endmodule
`default_nettype wire

// [bbs_properties.sv]
// pin-level assertions for the sram host controller
`default_nettype none
module bbs_properties (
  // clock, reset and status
  input wire logic ref_clk, reset, req_ready, power_good, mem_ready,
  // sram pins
  input wire logic [12:0] address_inputs,
  input wire logic chip_on_n, output_drive_enable_n, store_strobe_n,
  input wire logic [7:0] data_lines_out,
  input wire logic data_lines_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_oe_write: assert property (
    !store_strobe_n |-> output_drive_enable_n) else $error("oe low in write");
  chk_data_setup: assert property (
    !store_strobe_n |-> !data_lines_oe_n) else $error("no write data");
  chk_data_hold: assert property (
    $rose(store_strobe_n) |-> !data_lines_oe_n && $stable(data_lines_out))
    else $error("write data not held");
  chk_addr_hold: assert property (
    $rose(store_strobe_n) |-> $stable(address_inputs)) else $error("addr");
  chk_strobe_pair: assert property (
    !store_strobe_n |-> !chip_on_n) else $error("strobe without chip");
  chk_wr_width: assert property (
    $fell(store_strobe_n) |=> store_strobe_n) else $error("strobe width");
  chk_gap_after: assert property (
    $rose(chip_on_n) |=> chip_on_n) else $error("no gap after cycle");
  chk_power_block: assert property (
    !power_good [*3] |-> !mem_ready && !req_ready) else $error("ready");
endmodule
// the checker watches every controller instance
bind bbs_host bbs_properties i_chk (.ref_clk, .reset, .req_ready,
  .power_good, .mem_ready, .address_inputs, .chip_on_n,
  .output_drive_enable_n, .store_strobe_n, .data_lines_out,
  .data_lines_oe_n);
`default_nettype wire

// [bbs_sram_model.sv]
// behavioural 8k x 8 battery-backed sram
`default_nettype none
module bbs_sram_model (
  input wire logic [12:0] address_inputs,
  input wire logic chip_on_n, output_drive_enable_n, store_strobe_n,
  input wire logic [7:0] host_data,
  input wire logic host_oe_n, power_good, battery_mode,
  output var logic [7:0] dev_data = 8'hA5
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [8192];
  wire logic on = power_good && !battery_mode && !chip_on_n;
  // only the addressed byte; an undriven bus stores junk
  always @*
    if (on && !store_strobe_n)
      mem[address_inputs] = host_oe_n ? ~dev_data : host_data;
  // outputs never held past a strobe change
  always @(address_inputs, on, output_drive_enable_n, store_strobe_n) begin
    dev_data = ~dev_data;
    #70;
    if (on && !output_drive_enable_n && store_strobe_n)
      dev_data = mem[address_inputs];
  end
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the sram host controller
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset, req_valid, req_write, power_good, battery_mode;
  logic req_ready, rsp_valid, mem_ready, chip_on_n, store_strobe_n;
  logic output_drive_enable_n, data_lines_oe_n;
  logic [12:0] req_addr, address_inputs;
  logic [7:0] req_wdata, rsp_rdata, dev_data, data_lines_out;
  logic [12:0] ad [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
  logic [7:0] dt [3] = '{8'hA5, 8'h3C, 8'hF0};
  int error_cnt = 0, comparisons = 0, n;
  bbs_host #(.REC_CYCLES(4)) i_dut (.ref_clk, .reset, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_ready, .rsp_rdata, .rsp_valid, .power_good,
    .battery_mode, .mem_ready, .address_inputs, .chip_on_n,
    .output_drive_enable_n, .store_strobe_n, .data_lines_in(dev_data),
    .data_lines_out, .data_lines_oe_n);
  bbs_sram_model i_mem (.address_inputs, .chip_on_n, .output_drive_enable_n,
    .store_strobe_n, .host_data(data_lines_out), .host_oe_n(data_lines_oe_n),
    .dev_data, .power_good, .battery_mode);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // request held until taken; bounded so a stuck ready shows up
  task req(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++n < 50);
    `CHK(req_ready, 1'b1)
    req_valid <= 1'b0;
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    req(1'b0, a, 8'h00);
    n = 0;
    do @(posedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 5);
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_rdata, e)
  endtask
  // back-to-back writes then reads at both ends of the range
  task t_rw;
    for (int i = 0; i < 3; i++) req(1'b1, ad[i], dt[i]);
    for (int i = 2; i >= 0; i--) rd(ad[i], dt[i]);
  endtask
  // supply loss refuses access; recovery is counted; contents kept
  task t_power;
    @(posedge ref_clk);
    battery_mode <= 1'b1;
    #1 `CHK({mem_ready, req_ready}, 2'b00)
    @(posedge ref_clk);
    battery_mode <= 1'b0;
    power_good <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 `CHK({mem_ready, req_ready}, 2'b00)
    @(posedge ref_clk);
    power_good <= 1'b1;
    n = 0;
    do @(posedge ref_clk); while (req_ready !== 1'b1 && ++n < 20);
    `CHK(n, 5)
    rd(ad[1], dt[1]);
  endtask
  initial begin
    {reset, power_good} = 2'b11;
    {req_valid, req_write, battery_mode} = 3'b000;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_rw;
    t_power;
    report_and_stop;
  end
  // watchdog at 3000 cycles, far beyond the few dozen needed
  initial begin
    #300000;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
